//--- design/sdva_pkg.sv
// package of offsets, field layouts and types for the sd video adjust register bank
package sdva_pkg;

  // ----------------------------------------------------------------
  // register subaddresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SDVA_COPY_CTRL_ADDR   = 8'h99;
  localparam logic [7:0] SDVA_COPY_MID_ADDR    = 8'h9a;
  localparam logic [7:0] SDVA_COPY_LOW_ADDR    = 8'h9b;
  localparam logic [7:0] SDVA_SCALE_LOW_ADDR   = 8'h9c;
  localparam logic [7:0] SDVA_LUMA_SCALE_ADDR  = 8'h9d;
  localparam logic [7:0] SDVA_BLUE_SCALE_ADDR  = 8'h9e;
  localparam logic [7:0] SDVA_RED_SCALE_ADDR   = 8'h9f;
  localparam logic [7:0] SDVA_HUE_ADDR         = 8'ha0;
  localparam logic [7:0] SDVA_BRIGHT_ADDR      = 8'ha1;
  localparam logic [7:0] SDVA_SHAPE_GAIN_ADDR  = 8'ha2;
  localparam logic [7:0] SDVA_CORING_ADDR      = 8'ha3;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SDVA_REG_RESET        = 8'h00;
  localparam logic [7:0] SDVA_SHAPE_GAIN_MASK  = 8'h0f;
  localparam logic [7:0] SDVA_ALL_BITS_MASK    = 8'hff;

  // ----------------------------------------------------------------
  // field positions in the copy-info control register, plus the wide blank bit of the brightness register
  // ----------------------------------------------------------------
  localparam int SDVA_CTRL_CRC_BIT  = 4;
  localparam int SDVA_CTRL_ODD_BIT  = 5;
  localparam int SDVA_CTRL_EVEN_BIT = 6;
  localparam int SDVA_CTRL_WIDE_BIT = 7;
  localparam int SDVA_BLANK_BIT     = 7;

  // ----------------------------------------------------------------
  // gain decode constants
  // ----------------------------------------------------------------
  localparam logic [3:0] SDVA_SHAPE_UNITY_CODE = 4'h6;
  localparam logic [3:0] SDVA_SHAPE_MAX_CODE   = 4'hc;
  localparam logic [3:0] SDVA_CORING_MAX_CODE  = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sdva_host_req_s;

  typedef struct packed {
    logic [19:0]      copy_payload;
    logic [13:0]      wide_payload;
    logic             copy_odd_en;
    logic             copy_even_en;
    logic             copy_crc_en;
    logic             wide_en;
    logic             wide_blank;
    logic [9:0]       luma_scale;
    logic [9:0]       blue_scale;
    logic [9:0]       red_scale;
    logic [7:0]       hue;
    logic [6:0]       brightness;
    logic signed [4:0] shape_gain_steps;
    logic signed [5:0] border_coring;
    logic signed [5:0] data_coring;
  } sdva_video_ctrl_s;

endpackage

//--- design/sdva_regs.sv
// register bank for sd copy info, widescreen data, scaling, hue, brightness and coring
`timescale 1ns/10ps
module sdva_regs
  import sdva_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire sdva_host_req_s   host_req,
  input  wire logic             shape_filter_on,
  input  wire logic             noise_reduction_mode,
  output logic [7:0]            host_rdata,
  output logic                  host_rvalid,
  output logic                  host_hit,
  output sdva_video_ctrl_s      video_ctrl
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // coring gain in sixteenths; codes past 8 clamp to the largest step
  function automatic logic signed [5:0] coring_decode(input logic [3:0] code, input logic nr_mode);
    logic [3:0] n;
    n = (code > SDVA_CORING_MAX_CODE) ? SDVA_CORING_MAX_CODE : code;
    if (nr_mode) begin
      coring_decode = -$signed({1'b0, n, 1'b0});
    end else begin
      coring_decode = $signed({2'b00, n});
    end
  endfunction

  // true when the subaddress belongs to this bank
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a >= SDVA_COPY_CTRL_ADDR) && (a <= SDVA_CORING_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] copy_info_control;
  logic [7:0] copy_info_data_mid;
  logic [7:0] copy_info_data_low;
  logic [7:0] scale_low_bits;
  logic [7:0] luma_scale_high;
  logic [7:0] blue_diff_scale_high;
  logic [7:0] red_diff_scale_high;
  logic [7:0] hue_adjust;
  logic [7:0] brightness_and_wide_blank;
  logic [7:0] luma_shaping_gain;
  logic [7:0] noise_coring_gains;

  logic       wr_hit;
  logic [3:0] shape_code;
  logic [3:0] shape_clamped;

  assign wr_hit = host_req.wr && addr_mapped(host_req.addr);

  // host writes; all registers come up at zero so every insertion is off
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      copy_info_control         <= SDVA_REG_RESET;
      copy_info_data_mid        <= SDVA_REG_RESET;
      copy_info_data_low        <= SDVA_REG_RESET;
      scale_low_bits            <= SDVA_REG_RESET;
      luma_scale_high           <= SDVA_REG_RESET;
      blue_diff_scale_high      <= SDVA_REG_RESET;
      red_diff_scale_high       <= SDVA_REG_RESET;
      hue_adjust                <= SDVA_REG_RESET;
      brightness_and_wide_blank <= SDVA_REG_RESET;
      luma_shaping_gain         <= SDVA_REG_RESET;
      noise_coring_gains        <= SDVA_REG_RESET;
    end else if (wr_hit) begin
      case (host_req.addr)
        SDVA_COPY_CTRL_ADDR:  copy_info_control         <= host_req.wdata;
        SDVA_COPY_MID_ADDR:   copy_info_data_mid        <= host_req.wdata;
        SDVA_COPY_LOW_ADDR:   copy_info_data_low        <= host_req.wdata;
        SDVA_SCALE_LOW_ADDR:  scale_low_bits            <= host_req.wdata;
        SDVA_LUMA_SCALE_ADDR: luma_scale_high           <= host_req.wdata;
        SDVA_BLUE_SCALE_ADDR: blue_diff_scale_high      <= host_req.wdata;
        SDVA_RED_SCALE_ADDR:  red_diff_scale_high       <= host_req.wdata;
        SDVA_HUE_ADDR:        hue_adjust                <= host_req.wdata;
        SDVA_BRIGHT_ADDR:     brightness_and_wide_blank <= host_req.wdata;
        // reserved upper nibble is never stored, so it always reads zero
        SDVA_SHAPE_GAIN_ADDR: luma_shaping_gain         <= host_req.wdata & SDVA_SHAPE_GAIN_MASK;
        SDVA_CORING_ADDR:     noise_coring_gains        <= host_req.wdata;
        default:              copy_info_control         <= copy_info_control;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-back path
  // ----------------------------------------------------------------

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      host_rdata  <= SDVA_REG_RESET;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_req.rd;
      case (host_req.addr)
        SDVA_COPY_CTRL_ADDR:  host_rdata <= copy_info_control;
        SDVA_COPY_MID_ADDR:   host_rdata <= copy_info_data_mid;
        SDVA_COPY_LOW_ADDR:   host_rdata <= copy_info_data_low;
        SDVA_SCALE_LOW_ADDR:  host_rdata <= scale_low_bits;
        SDVA_LUMA_SCALE_ADDR: host_rdata <= luma_scale_high;
        SDVA_BLUE_SCALE_ADDR: host_rdata <= blue_diff_scale_high;
        SDVA_RED_SCALE_ADDR:  host_rdata <= red_diff_scale_high;
        SDVA_HUE_ADDR:        host_rdata <= hue_adjust;
        SDVA_BRIGHT_ADDR:     host_rdata <= brightness_and_wide_blank;
        SDVA_SHAPE_GAIN_ADDR: host_rdata <= luma_shaping_gain;
        SDVA_CORING_ADDR:     host_rdata <= noise_coring_gains;
        default:              host_rdata <= SDVA_REG_RESET;
      endcase
    end
  end

  // hit tells the serial port whether to acknowledge the subaddress
  assign host_hit = addr_mapped(host_req.addr);

  // ----------------------------------------------------------------
  // video-facing decode
  // ----------------------------------------------------------------

  // codes above the top step are held at +4 dB rather than wrapping
  assign shape_code    = luma_shaping_gain[3:0];
  assign shape_clamped = (shape_code > SDVA_SHAPE_MAX_CODE) ? SDVA_SHAPE_MAX_CODE : shape_code;

  // registered one cycle behind the bank; a field split over several registers shows each write as it lands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      video_ctrl <= '0;
    end else begin
      video_ctrl.copy_payload     <= {copy_info_control[3:0], copy_info_data_mid,
                                      copy_info_data_low};
      video_ctrl.wide_payload     <= {copy_info_data_mid[5:0], copy_info_data_low};
      video_ctrl.copy_odd_en      <= copy_info_control[SDVA_CTRL_ODD_BIT];
      video_ctrl.copy_even_en     <= copy_info_control[SDVA_CTRL_EVEN_BIT];
      video_ctrl.copy_crc_en      <= copy_info_control[SDVA_CTRL_CRC_BIT];
      video_ctrl.wide_en          <= copy_info_control[SDVA_CTRL_WIDE_BIT];
      video_ctrl.luma_scale       <= {luma_scale_high, scale_low_bits[1:0]};
      video_ctrl.blue_scale       <= {blue_diff_scale_high, scale_low_bits[3:2]};
      video_ctrl.red_scale        <= {red_diff_scale_high, scale_low_bits[5:4]};
      video_ctrl.hue              <= hue_adjust;
      video_ctrl.brightness       <= brightness_and_wide_blank[6:0];
      video_ctrl.wide_blank       <= brightness_and_wide_blank[SDVA_BLANK_BIT];
      // filter off means unity gain, whatever the field holds
      video_ctrl.shape_gain_steps <= shape_filter_on ?
                                     $signed({1'b0, shape_clamped}) - $signed({1'b0, SDVA_SHAPE_UNITY_CODE}) :
                                     5'sd0;
      video_ctrl.border_coring    <= coring_decode(noise_coring_gains[3:0], noise_reduction_mode);
      video_ctrl.data_coring      <= coring_decode(noise_coring_gains[7:4], noise_reduction_mode);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence ctrl_write_s;
    host_req.wr && host_req.addr == SDVA_COPY_CTRL_ADDR;
  endsequence

  sequence low_write_s;
    host_req.wr && host_req.addr == SDVA_COPY_LOW_ADDR;
  endsequence

  copy_payload_a: assert property (ctrl_write_s |-> ##2
    video_ctrl.copy_payload[19:16] == $past(host_req.wdata[3:0], 2))
    else $error("copy payload top nibble not taken from control write");

  wide_payload_a: assert property (low_write_s |-> ##2
    video_ctrl.wide_payload[7:0] == $past(host_req.wdata, 2)
    && video_ctrl.copy_payload[7:0] == $past(host_req.wdata, 2))
    else $error("low payload byte not shared by copy and widescreen");

  odd_enable_a: assert property (ctrl_write_s |-> ##2
    video_ctrl.copy_odd_en == $past(host_req.wdata[5], 2))
    else $error("odd field enable does not follow bit 5");

  even_enable_a: assert property (ctrl_write_s |-> ##2
    video_ctrl.copy_even_en == $past(host_req.wdata[6], 2))
    else $error("even field enable does not follow bit 6");

  crc_wide_enable_a: assert property (ctrl_write_s |-> ##2
    video_ctrl.copy_crc_en == $past(host_req.wdata[4], 2)
    && video_ctrl.wide_en == $past(host_req.wdata[7], 2))
    else $error("crc or widescreen enable wrong");

  luma_scale_a: assert property (##1 video_ctrl.luma_scale == $past({luma_scale_high, scale_low_bits[1:0]}))
    else $error("luma scale assembly wrong");

  blue_scale_a: assert property (##1 video_ctrl.blue_scale == $past({blue_diff_scale_high, scale_low_bits[3:2]}))
    else $error("blue scale assembly wrong");

  red_scale_a: assert property (##1 video_ctrl.red_scale == $past({red_diff_scale_high, scale_low_bits[5:4]}))
    else $error("red scale assembly wrong");

  hue_value_a: assert property (host_req.wr && host_req.addr == SDVA_HUE_ADDR |-> ##2
    video_ctrl.hue == $past(host_req.wdata, 2))
    else $error("hue does not follow its register");

  wide_blank_a: assert property (host_req.wr && host_req.addr == SDVA_BRIGHT_ADDR |-> ##2
    video_ctrl.wide_blank == $past(host_req.wdata[7], 2)
    && video_ctrl.brightness == $past(host_req.wdata[6:0], 2))
    else $error("brightness or blank bit wrong");

  shape_reserved_a: assert property (host_req.rd && host_req.addr == SDVA_SHAPE_GAIN_ADDR |=>
    host_rdata[7:4] == 4'h0)
    else $error("reserved shaping bits read nonzero");

  shape_gate_a: assert property (!shape_filter_on |=> video_ctrl.shape_gain_steps == 5'sd0)
    else $error("shaping gain applied while filter disabled");

  shape_unity_a: assert property (shape_filter_on && luma_shaping_gain[3:0] == SDVA_SHAPE_UNITY_CODE |=>
    video_ctrl.shape_gain_steps == 5'sd0)
    else $error("unity code does not give zero gain");

  border_nr_a: assert property (noise_reduction_mode && noise_coring_gains[3:0] == SDVA_CORING_MAX_CODE |=>
    video_ctrl.border_coring == -6'sd16)
    else $error("border coring top code in nr mode is not -1");

  data_normal_a: assert property (!noise_reduction_mode && noise_coring_gains[7:4] == 4'h3 |=>
    video_ctrl.data_coring == 6'sd3)
    else $error("data coring normal scale wrong");

  // middle payload byte feeds copy bits 15:8 and widescreen bits 13:8
  copy_mid_a: assert property (host_req.wr && host_req.addr == SDVA_COPY_MID_ADDR |-> ##2
    video_ctrl.copy_payload[15:8] == $past(host_req.wdata, 2))
    else $error("copy payload middle byte not taken from its register");

  wide_mid_a: assert property (host_req.wr && host_req.addr == SDVA_COPY_MID_ADDR |-> ##2
    video_ctrl.wide_payload[13:8] == $past(host_req.wdata[5:0], 2))
    else $error("widescreen upper bits not taken from middle register");

  // the read handshake is the read strobe registered by one cycle
  rvalid_pulse_a: assert property (host_req.rd |=>
    host_rvalid)
    else $error("read strobe not answered one cycle later");

  rvalid_idle_a: assert property (!host_req.rd |=>
    !host_rvalid)
    else $error("read valid without a read strobe");

  hit_range_a: assert property (host_hit ==
    ((host_req.addr >= SDVA_COPY_CTRL_ADDR) && (host_req.addr <= SDVA_CORING_ADDR)))
    else $error("hit does not match the bank address range");

  unmapped_read_a: assert property (host_req.rd && !host_hit |=>
    host_rdata == SDVA_REG_RESET)
    else $error("unmapped read returned nonzero data");

  unmapped_write_a: assert property (host_req.wr && !host_hit |=>
    $stable(copy_info_control) && $stable(noise_coring_gains) && $stable(hue_adjust))
    else $error("unmapped write changed a register");

  ctrl_hold_a: assert property (!(host_req.wr && host_req.addr == SDVA_COPY_CTRL_ADDR) |=>
    $stable(copy_info_control))
    else $error("control register changed without a write");

  shape_store_a: assert property (host_req.wr && host_req.addr == SDVA_SHAPE_GAIN_ADDR |=>
    luma_shaping_gain == {4'h0, $past(host_req.wdata[3:0])})
    else $error("shaping gain field not stored as written");

  // end points of the shaping scale, plus the clamp above the top code
  shape_top_a: assert property (shape_filter_on && luma_shaping_gain[3:0] == SDVA_SHAPE_MAX_CODE |=>
    video_ctrl.shape_gain_steps == 5'sd6)
    else $error("top shaping code does not give the largest boost");

  shape_bottom_a: assert property (shape_filter_on && luma_shaping_gain[3:0] == 4'h0 |=>
    video_ctrl.shape_gain_steps == -5'sd6)
    else $error("bottom shaping code does not give the largest cut");

  shape_clamp_a: assert property (shape_filter_on && luma_shaping_gain[3:0] > SDVA_SHAPE_MAX_CODE |=>
    video_ctrl.shape_gain_steps == 5'sd6)
    else $error("shaping code above the top step not clamped");

  shape_range_a: assert property (video_ctrl.shape_gain_steps >= -5'sd6 &&
    video_ctrl.shape_gain_steps <= 5'sd6)
    else $error("shaping gain outside its range");

  // coring checks in both modes, zero code and clamped codes
  border_normal_a: assert property (!noise_reduction_mode && noise_coring_gains[3:0] == 4'h1 |=>
    video_ctrl.border_coring == 6'sd1)
    else $error("border coring normal scale wrong");

  border_zero_a: assert property (noise_coring_gains[3:0] == 4'h0 |=>
    video_ctrl.border_coring == 6'sd0)
    else $error("border coring zero code gives gain");

  border_clamp_a: assert property (!noise_reduction_mode && noise_coring_gains[3:0] > SDVA_CORING_MAX_CODE |=>
    video_ctrl.border_coring == 6'sd8)
    else $error("border coring code above eight not clamped");

  data_nr_a: assert property (noise_reduction_mode && noise_coring_gains[7:4] == SDVA_CORING_MAX_CODE |=>
    video_ctrl.data_coring == -6'sd16)
    else $error("data coring top code in nr mode is not -1");

  data_zero_a: assert property (noise_coring_gains[7:4] == 4'h0 |=>
    video_ctrl.data_coring == 6'sd0)
    else $error("data coring zero code gives gain");

  data_clamp_a: assert property (noise_reduction_mode && noise_coring_gains[7:4] > SDVA_CORING_MAX_CODE |=>
    video_ctrl.data_coring == -6'sd16)
    else $error("data coring code above eight not clamped in nr mode");

  hue_store_a: assert property (host_req.wr && host_req.addr == SDVA_HUE_ADDR |=>
    hue_adjust == $past(host_req.wdata))
    else $error("hue register not stored as written");

  // scale low pairs land in the right slot of each factor
  luma_low_a: assert property (host_req.wr && host_req.addr == SDVA_SCALE_LOW_ADDR |-> ##2
    video_ctrl.luma_scale[1:0] == $past(host_req.wdata[1:0], 2))
    else $error("luma scale low pair wrong");

  blue_low_a: assert property (host_req.wr && host_req.addr == SDVA_SCALE_LOW_ADDR |-> ##2
    video_ctrl.blue_scale[1:0] == $past(host_req.wdata[3:2], 2))
    else $error("blue scale low pair wrong");

  red_low_a: assert property (host_req.wr && host_req.addr == SDVA_SCALE_LOW_ADDR |-> ##2
    video_ctrl.red_scale[1:0] == $past(host_req.wdata[5:4], 2))
    else $error("red scale low pair wrong");

  luma_high_a: assert property (host_req.wr && host_req.addr == SDVA_LUMA_SCALE_ADDR |-> ##2
    video_ctrl.luma_scale[9:2] == $past(host_req.wdata, 2))
    else $error("luma scale upper bits wrong");

  blue_high_a: assert property (host_req.wr && host_req.addr == SDVA_BLUE_SCALE_ADDR |-> ##2
    video_ctrl.blue_scale[9:2] == $past(host_req.wdata, 2))
    else $error("blue scale upper bits wrong");

  red_high_a: assert property (host_req.wr && host_req.addr == SDVA_RED_SCALE_ADDR |-> ##2
    video_ctrl.red_scale[9:2] == $past(host_req.wdata, 2))
    else $error("red scale upper bits wrong");

endmodule

//--- dv/tb_top.sv
// self-checking testbench for the sd video adjust register bank
`timescale 1ns/10ps
module tb_top
  import sdva_pkg::*;
;
  logic             clk_sys;
  logic             nrst;
  sdva_host_req_s   host_req;
  logic             shape_filter_on;
  logic             noise_reduction_mode;
  logic [7:0]       host_rdata;
  logic             host_rvalid;
  logic             host_hit;
  sdva_video_ctrl_s video_ctrl;
  int               error_cnt;
  int               checks_done;

  // ----------------------------------------------------------------
  // clock, device and common tasks
  // ----------------------------------------------------------------
  // free running 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  sdva_regs i_dut (
    .clk_sys              (clk_sys),
    .nrst                 (nrst),
    .host_req             (host_req),
    .shape_filter_on      (shape_filter_on),
    .noise_reduction_mode (noise_reduction_mode),
    .host_rdata           (host_rdata),
    .host_rvalid          (host_rvalid),
    .host_hit             (host_hit),
    .video_ctrl           (video_ctrl)
  );

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle write strobe, dropped at the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    host_req.wr <= 1'b0;
  endtask

  // read pulse, data checked in the single valid cycle, then valid must drop
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    #1 chk(host_hit, (a >= 8'h99 && a <= 8'ha3));
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1 chk(host_rvalid, 1'b1);
    chk(host_rdata, e);
    @(posedge clk_sys);
    #1 chk(host_rvalid, 1'b0);
  endtask

  // decoded outputs land two edges after the write, mode inputs one edge
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset state, then full readback with unmapped places left untouched
  task automatic t_regs();
    logic [7:0] a;
    for (int i = 0; i < 11; i++) rd_reg(8'h99 + 8'(i), SDVA_REG_RESET);
    chk(video_ctrl, '0);
    for (int i = 0; i < 11; i++) wr_reg(8'h99 + 8'(i), 8'ha5 ^ 8'(i * 17));
    wr_reg(8'h98, 8'hff);
    wr_reg(8'ha4, 8'hff);
    for (int i = 0; i < 11; i++) begin
      a = 8'h99 + 8'(i);
      rd_reg(a, (8'ha5 ^ 8'(i * 17)) & ((a == SDVA_SHAPE_GAIN_ADDR) ? SDVA_SHAPE_GAIN_MASK : 8'hff));
    end
    rd_reg(8'h98, 8'h00);
    rd_reg(8'ha4, 8'h00);
  endtask

  // payload assembly and the four insertion enables, both polarities
  task automatic t_copy();
    wr_reg(SDVA_COPY_CTRL_ADDR, 8'hb7);
    wr_reg(SDVA_COPY_MID_ADDR, 8'hc5);
    wr_reg(SDVA_COPY_LOW_ADDR, 8'h3e);
    settle();
    chk(video_ctrl.copy_payload, 20'h7c53e);
    chk(video_ctrl.wide_payload, {6'h05, 8'h3e});
    chk({video_ctrl.copy_odd_en, video_ctrl.copy_even_en}, 2'b10);
    chk({video_ctrl.copy_crc_en, video_ctrl.wide_en}, 2'b11);
    wr_reg(SDVA_COPY_CTRL_ADDR, 8'h4a);
    settle();
    chk(video_ctrl.copy_payload, 20'hac53e);
    chk({video_ctrl.copy_odd_en, video_ctrl.copy_even_en}, 2'b01);
    chk({video_ctrl.copy_crc_en, video_ctrl.wide_en}, 2'b00);
  endtask

  // each scale low pair is distinct so a swapped slice shows up
  task automatic t_scale();
    wr_reg(SDVA_SCALE_LOW_ADDR, 8'he4);
    wr_reg(SDVA_LUMA_SCALE_ADDR, 8'hab);
    wr_reg(SDVA_BLUE_SCALE_ADDR, 8'h12);
    wr_reg(SDVA_RED_SCALE_ADDR, 8'hfe);
    wr_reg(SDVA_HUE_ADDR, 8'h9c);
    wr_reg(SDVA_BRIGHT_ADDR, 8'hd3);
    settle();
    chk(video_ctrl.luma_scale, {8'hab, 2'b00});
    chk(video_ctrl.blue_scale, {8'h12, 2'b01});
    chk(video_ctrl.red_scale, {8'hfe, 2'b10});
    chk(video_ctrl.hue, 8'h9c);
    chk({video_ctrl.wide_blank, video_ctrl.brightness}, 8'hd3);
    wr_reg(SDVA_BRIGHT_ADDR, 8'h7f);
    settle();
    chk({video_ctrl.wide_blank, video_ctrl.brightness}, 8'h7f);
  endtask

  // shaping gain at the ends, the unity code and a clamped code
  task automatic t_shape();
    logic [3:0] codes [5] = '{4'h0, 4'h5, 4'h6, 4'hc, 4'hf};
    int         e;
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_sys) shape_filter_on <= f[0];
      foreach (codes[i]) begin
        wr_reg(SDVA_SHAPE_GAIN_ADDR, {4'h0, codes[i]});
        settle();
        e = (f == 0) ? 0 : ((codes[i] > 4'hc) ? 12 : int'(codes[i])) - 6;
        chk({27'h0, video_ctrl.shape_gain_steps}, {27'h0, 5'(e)});
      end
    end
    @(posedge clk_sys) shape_filter_on <= 1'b0;
  endtask

  // coring codes through the scale in both modes, clamp above eight
  task automatic t_coring();
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hf};
    logic [3:0] b;
    logic [3:0] d;
    int         eb;
    int         ed;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys) noise_reduction_mode <= m[0];
      foreach (codes[i]) begin
        b = codes[i];
        d = codes[(i + 3) % 6];
        wr_reg(SDVA_CORING_ADDR, {d, b});
        settle();
        eb = (b > 4'h8) ? 8 : int'(b);
        ed = (d > 4'h8) ? 8 : int'(d);
        if (m == 1) begin
          eb = -2 * eb;
          ed = -2 * ed;
        end
        chk({26'h0, video_ctrl.border_coring}, {26'h0, 6'(eb)});
        chk({26'h0, video_ctrl.data_coring}, {26'h0, 6'(ed)});
      end
    end
    @(posedge clk_sys) noise_reduction_mode <= 1'b0;
  endtask

  // second reset in mid-run clears every register again
  task automatic t_rereset();
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 chk(video_ctrl, '0);
    rd_reg(SDVA_COPY_CTRL_ADDR, SDVA_REG_RESET);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    host_req = '0;
    shape_filter_on = 1'b0;
    noise_reduction_mode = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_copy();
    t_scale();
    t_shape();
    t_coring();
    t_rereset();
    give_verdict();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
endmodule
